// ==== verilog/pitc_map.svh ====
// offsets, field positions, reset values and timing counts of the
// priority interrupt and event transfer block
// assumes byte addresses on an axi4-lite bus with 32-bit data
// Operation
// - event transfer moves byte or word, optional increment
// - transfer steals one cycle, saves no status
// - each source has request, enable, level control
// - accepted service preempted only by higher level
// - groups keep equal-level tasks from interrupting
// - each source branches to its own vector
// - multiply and divide interruptible mid execution
// - fast external inputs sampled every 12 cycles, 48 ns at 4 ns
// - hardware trap branches and sets trap flag
// - trap preempts all but equal or higher trap service
// - trap service blocks interrupts and transfers
// - software trap number selects the vector
// - pending sources arbitrated again every cycle
// - transfer starts, else compare with status level
// - acknowledge pushes state then branches to vector
// - eight channels with count and control registers
// - counter decrements per transfer unless continuous
// - counter at zero raises standard cpu interrupt
// - stack pointer checked against upper limit on push, lower limit on return
`ifndef PITC_MAP_SVH
`define PITC_MAP_SVH
`define PITC_SRC_BASE 8'h00
`define PITC_PSW 8'h40
`define PITC_TFR 8'h44
`define PITC_SP 8'h48
`define PITC_STK_UP 8'h4C
`define PITC_STK_LO 8'h50
`define PITC_STATUS 8'h54
`define PITC_CH_CTL 8'h80
`define PITC_CH_SRC 8'hA0
`define PITC_CH_DST 8'hC0
`define PITC_PSW_LVL 15:12
`define PITC_PSW_RST 16'h0000
`define PITC_SP_RST 16'hFC00
`define PITC_STK_UP_RST 16'hF400
`define PITC_STK_LO_RST 16'hFC00
`define PITC_STK_STEP 16'h0002
`define PITC_STEP_BYTE 16'h0001
`define PITC_STEP_WORD 16'h0002
`define PITC_IRQ_VEC_BASE 16'h0040
`define PITC_TRAP_VEC_BASE 16'h0000
`define PITC_SWI_VEC_BASE 16'h0000
`define PITC_TRAP_STACK_UPPER_LIMIT 0
`define PITC_TRAP_STACK_LOWER_LIMIT 1
`define PITC_TRAP_PIN_LSB 2
`define PITC_RESP_OK 2'h0
`define PITC_RESP_ERR 2'h2
`define PITC_CLK_NS 4
`define PITC_FAST_SAMPLE_NS 50
`endif

// ==== verilog/pitc_pkg.sv ====
// types of the priority interrupt and event transfer block
// assumes the field layout given in pitc_map.svh
package pitc_pkg;
    // source control word, bits 11:0
    typedef struct packed {
        logic xfer;
        logic [2:0] chan;
        logic [1:0] group;
        logic [3:0] level;
        logic en;
        logic req;
    } pitc_src_ctrl_t;
    // channel control word, bits 11:0
    typedef struct packed {
        logic cont;
        logic inc_dst;
        logic inc_src;
        logic word;
        logic [7:0] count;
    } pitc_chan_ctrl_t;
    typedef struct packed {
        logic word;
        logic [15:0] src;
        logic [15:0] dst;
    } pitc_move_t;
    typedef enum logic {SV_TASK, SV_TRAP} pitc_svc_t;
endpackage

// ==== verilog/pitc_arb.sv ====
// priority arbiter over all requesting sources
// assumes candidates and control words from the same clock domain
`timescale 1ns/10ps
module pitc_arb #(
    parameter int N_SRC = 16
) (
    input wire logic [N_SRC-1:0] cand,
    input pitc_pkg::pitc_src_ctrl_t ctrl [N_SRC],
    output logic win,
    output logic [$clog2(N_SRC)-1:0] win_idx,
    output logic [3:0] win_level
);
    function automatic logic [5:0] rank(input pitc_pkg::pitc_src_ctrl_t c);
        return {c.level, c.group};
    endfunction

    logic [5:0] best;

    // strictly greater only, so lower index wins a full tie
    always_comb begin
        win = 1'b0;
        win_idx = '0;
        best = 6'h00;
        for (int i = 0; i < N_SRC; i++) begin
            if (cand[i] && (!win || rank(ctrl[i]) > best)) begin
                win = 1'b1;
                win_idx = ($clog2(N_SRC))'(i);
                best = rank(ctrl[i]);
            end
        end
        win_level = best[5:2];
    end
endmodule // pitc_arb

// ==== verilog/pitc_top.sv ====
// interrupt controller with event transfer channels, traps, stack checks
// assumes an axi4-lite master on aclk; pins are asynchronous
`timescale 1ns/10ps
`include "pitc_map.svh"
module pitc_top #(
    parameter int N_SRC = 16,
    parameter int N_FAST = 4,
    parameter int N_CHAN = 8,
    parameter int N_TPIN = 6,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [N_SRC-1:0] src_pin,
    input wire logic [N_FAST-1:0] fast_pin,
    input wire logic [N_TPIN-1:0] trap_pin,
    input wire logic cpu_ack,
    input wire logic trap_ack,
    input wire logic swi_valid,
    input wire logic [7:0] swi_num,
    input wire logic reti,
    input wire logic [15:0] reti_psw,
    input wire logic mdu_busy,
    output logic irq_valid,
    output logic [15:0] irq_vector,
    output logic [3:0] irq_level,
    output logic trap_valid,
    output logic [15:0] trap_vector,
    output logic [15:0] swi_vector,
    output logic mdu_abort,
    output logic xfer_valid,
    output pitc_pkg::pitc_move_t xfer_move,
    output logic cpu_stall,
    output logic stk_push,
    output logic [15:0] stk_addr,
    output logic [15:0] stk_data
);
    localparam int IW = $clog2(N_SRC);
    localparam int CW = $clog2(N_CHAN);
    localparam int NT = N_TPIN + 2;
    localparam int FAST_CYC = `PITC_FAST_SAMPLE_NS / `PITC_CLK_NS;

    function automatic logic [15:0] vec_of(input logic [15:0] base,
                                           input logic [7:0] idx);
        return base + {6'h00, idx, 2'b00};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                old[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return old;
    endfunction

    function automatic logic in_area(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] base,
                                     input int n);
        return int'(a) >= int'(base) && int'(a) < int'(base) + n * 4;
    endfunction

    pitc_pkg::pitc_src_ctrl_t ctrl [N_SRC];
    pitc_pkg::pitc_chan_ctrl_t ch [N_CHAN];
    logic [15:0] ch_src [N_CHAN];
    logic [15:0] ch_dst [N_CHAN];
    pitc_pkg::pitc_svc_t svc;
    logic [15:0] processor_status_word, sp, stk_upper, stk_lower;
    logic [NT-1:0] trap_flag_register, trap_pend;
    logic [7:0] trap_cur, trap_idx, trap_idx_q;
    logic [IW-1:0] irq_idx;
    logic [N_SRC-1:0] src_s1, src_s2, src_s3;
    logic [N_FAST-1:0] fast_s1, fast_s2, fast_seen;
    logic [N_TPIN-1:0] trap_s1, trap_s2, trap_s3;
    logic [3:0] fast_cnt;
    logic fast_tick;
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // pins pass two flip-flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_s1 <= '0;
            src_s2 <= '0;
            src_s3 <= '0;
            fast_s1 <= '0;
            fast_s2 <= '0;
            trap_s1 <= '0;
            trap_s2 <= '0;
            trap_s3 <= '0;
        end else begin
            src_s1 <= src_pin;
            src_s2 <= src_s1;
            src_s3 <= src_s2;
            fast_s1 <= fast_pin;
            fast_s2 <= fast_s1;
            trap_s1 <= trap_pin;
            trap_s2 <= trap_s1;
            trap_s3 <= trap_s2;
        end
    end

    // fast inputs: any high level inside a window is caught at its tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_cnt <= 4'h0;
            fast_tick <= 1'b0;
            fast_seen <= '0;
        end else begin
            fast_tick <= fast_cnt == 4'(FAST_CYC - 1);
            fast_cnt <= fast_cnt == 4'(FAST_CYC - 1) ? 4'h0 : fast_cnt + 4'h1;
            fast_seen <= fast_tick ? fast_s2 : fast_seen | fast_s2;
        end
    end

    logic [N_SRC-1:0] hw_set, cand;
    logic win, use_xfer, quiet, trap_any, trap_can, can_irq, do_xfer;
    logic irq_take, trap_take, push_ev, ovf_hit, unf_hit, wr_fire;
    logic [IW-1:0] win_idx;
    logic [3:0] win_level;
    logic [15:0] next_sp;
    logic [NT-1:0] trap_set;
    pitc_pkg::pitc_src_ctrl_t sel;
    pitc_pkg::pitc_chan_ctrl_t chs;
    logic [CW-1:0] cur_ch;

    always_comb begin
        hw_set = src_s2 & ~src_s3;
        if (fast_tick) begin
            hw_set = hw_set | {{(N_SRC - N_FAST){1'b0}}, fast_seen};
        end
        for (int i = 0; i < N_SRC; i++) begin
            cand[i] = ctrl[i].req && ctrl[i].en && ctrl[i].level != 4'h0;
        end
    end

    pitc_arb #(.N_SRC(N_SRC)) u_arb (
        .cand(cand),
        .ctrl(ctrl),
        .win(win),
        .win_idx(win_idx),
        .win_level(win_level)
    );

    always_comb begin
        sel = ctrl[win_idx];
        cur_ch = CW'(sel.chan);
        chs = ch[cur_ch];
        trap_any = 1'b0;
        trap_idx = 8'h00;
        for (int t = NT - 1; t >= 0; t--) begin
            if (trap_pend[t]) begin
                trap_any = 1'b1;
                trap_idx = 8'(t);
            end
        end
        irq_take = irq_valid && cpu_ack;
        trap_take = trap_valid && trap_ack;
        trap_can = trap_any && !trap_take &&
                   (svc == pitc_pkg::SV_TASK || trap_idx < trap_cur);
        quiet = svc == pitc_pkg::SV_TASK && !trap_can && !trap_valid;
        use_xfer = sel.xfer && chs.count != 8'h00;
        do_xfer = quiet && win && use_xfer;
        can_irq = quiet && win && !use_xfer && !irq_take &&
                  win_level > processor_status_word[`PITC_PSW_LVL];
        push_ev = irq_take || trap_take || swi_valid;
        next_sp = push_ev ? sp - `PITC_STK_STEP : sp + `PITC_STK_STEP;
        ovf_hit = push_ev && next_sp < stk_upper;
        unf_hit = !push_ev && reti && next_sp > stk_lower;
        trap_set = {(trap_s2 & ~trap_s3), unf_hit, ovf_hit};
        wr_fire = aw_held && w_held && !bvalid;
    end

    // requests to the cpu and the transfer port, re-decided every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_valid <= 1'b0;
            irq_idx <= '0;
            irq_level <= 4'h0;
            irq_vector <= 16'h0000;
            trap_valid <= 1'b0;
            trap_idx_q <= 8'h00;
            trap_vector <= 16'h0000;
            swi_vector <= 16'h0000;
            mdu_abort <= 1'b0;
            xfer_valid <= 1'b0;
            cpu_stall <= 1'b0;
            xfer_move <= '0;
        end else begin
            irq_valid <= can_irq;
            irq_idx <= win_idx;
            irq_level <= win_level;
            irq_vector <= vec_of(`PITC_IRQ_VEC_BASE, 8'(win_idx));
            trap_valid <= trap_can;
            trap_idx_q <= trap_idx;
            trap_vector <= vec_of(`PITC_TRAP_VEC_BASE, trap_idx);
            if (swi_valid) begin
                swi_vector <= vec_of(`PITC_SWI_VEC_BASE, swi_num);
            end
            mdu_abort <= irq_take && mdu_busy;
            xfer_valid <= do_xfer;
            cpu_stall <= do_xfer;
            xfer_move <= '{word: chs.word, src: ch_src[cur_ch],
                           dst: ch_dst[cur_ch]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            svc <= pitc_pkg::SV_TASK;
            trap_cur <= 8'h00;
        end else if (trap_take) begin
            svc <= pitc_pkg::SV_TRAP;
            trap_cur <= trap_idx_q;
        end else if (reti && svc == pitc_pkg::SV_TRAP) begin
            svc <= pitc_pkg::SV_TASK;
        end
    end

    // trap flags: set wins over the write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_flag_register <= '0;
            trap_pend <= '0;
        end else begin
            if (wr_fire && aw_addr == `PITC_TFR && w_strb[0]) begin
                trap_flag_register <= (trap_flag_register & ~w_data[NT-1:0]) | trap_set;
            end else begin
                trap_flag_register <= trap_flag_register | trap_set;
            end
            trap_pend <= (trap_pend & ~(trap_take ? NT'(1) << trap_idx_q :
                          NT'(0))) | trap_set;
        end
    end

    // status word and system stack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_status_word <= `PITC_PSW_RST;
            sp <= `PITC_SP_RST;
            stk_upper <= `PITC_STK_UP_RST;
            stk_lower <= `PITC_STK_LO_RST;
            stk_push <= 1'b0;
            stk_addr <= 16'h0000;
            stk_data <= 16'h0000;
        end else begin
            stk_push <= push_ev;
            if (wr_fire) begin
                unique case (aw_addr)
                    `PITC_PSW: processor_status_word <= 16'(merge(32'(processor_status_word), w_data, w_strb));
                    `PITC_SP: sp <= 16'(merge(32'(sp), w_data, w_strb));
                    `PITC_STK_UP: stk_upper <= 16'(merge(32'(stk_upper),
                                                       w_data, w_strb));
                    `PITC_STK_LO: stk_lower <= 16'(merge(32'(stk_lower),
                                                       w_data, w_strb));
                    default: ;
                endcase
            end
            if (push_ev) begin
                sp <= next_sp;
                stk_addr <= next_sp;
                stk_data <= processor_status_word;
                if (irq_take) begin
                    processor_status_word[`PITC_PSW_LVL] <= irq_level;
                end
            end else if (reti) begin
                sp <= next_sp;
                processor_status_word <= reti_psw;
            end
        end
    end

    // source control words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N_SRC; i++) begin
                ctrl[i] <= '0;
            end
        end else begin
            for (int i = 0; i < N_SRC; i++) begin
                pitc_pkg::pitc_src_ctrl_t c;
                c = ctrl[i];
                if (wr_fire && in_area(aw_addr, `PITC_SRC_BASE, N_SRC) &&
                    IW'((aw_addr - `PITC_SRC_BASE) >> 2) == IW'(i)) begin
                    c = 12'(merge(32'(ctrl[i]), w_data, w_strb));
                end
                if (do_xfer && win_idx == IW'(i)) begin
                    c.req = 1'b0;
                    if (!chs.cont && chs.count == 8'h01) begin
                        c.req = 1'b1;
                        c.xfer = 1'b0;
                    end
                end
                if (irq_take && irq_idx == IW'(i)) begin
                    c.req = 1'b0;
                end
                c.req = c.req | hw_set[i];
                ctrl[i] <= c;
            end
        end
    end

    // transfer channels and their pointers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < N_CHAN; k++) begin
                ch[k] <= '0;
                ch_src[k] <= 16'h0000;
                ch_dst[k] <= 16'h0000;
            end
        end else begin
            for (int k = 0; k < N_CHAN; k++) begin
                if (wr_fire && aw_addr == `PITC_CH_CTL + ADDR_W'(4 * k)) begin
                    ch[k] <= 12'(merge(32'(ch[k]), w_data, w_strb));
                end
                if (wr_fire && aw_addr == `PITC_CH_SRC + ADDR_W'(4 * k)) begin
                    ch_src[k] <= 16'(merge(32'(ch_src[k]), w_data, w_strb));
                end
                if (wr_fire && aw_addr == `PITC_CH_DST + ADDR_W'(4 * k)) begin
                    ch_dst[k] <= 16'(merge(32'(ch_dst[k]), w_data, w_strb));
                end
            end
            if (do_xfer) begin
                if (!chs.cont) begin
                    ch[cur_ch].count <= chs.count - 8'h01;
                end
                if (chs.inc_src) begin
                    ch_src[cur_ch] <= ch_src[cur_ch] + (chs.word ?
                        `PITC_STEP_WORD : `PITC_STEP_BYTE);
                end else if (chs.inc_dst) begin
                    ch_dst[cur_ch] <= ch_dst[cur_ch] + (chs.word ?
                        `PITC_STEP_WORD : `PITC_STEP_BYTE);
                end
            end
        end
    end

    // axi4-lite write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `PITC_RESP_OK;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= rd_map_ok(aw_addr) ? `PITC_RESP_OK : `PITC_RESP_ERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    function automatic logic rd_map_ok(input logic [ADDR_W-1:0] a);
        return in_area(a, `PITC_SRC_BASE, N_SRC) ||
               in_area(a, `PITC_CH_CTL, N_CHAN) ||
               in_area(a, `PITC_CH_SRC, N_CHAN) ||
               in_area(a, `PITC_CH_DST, N_CHAN) ||
               in_area(a, `PITC_PSW, 6);
    endfunction

    logic [31:0] rd_data;
    logic [ADDR_W-1:0] ri;

    always_comb begin
        rd_data = 32'h0000_0000;
        ri = (araddr >> 2) & ADDR_W'(N_SRC - 1);
        if (in_area(araddr, `PITC_SRC_BASE, N_SRC)) begin
            rd_data = 32'(ctrl[IW'(ri)]);
        end else if (in_area(araddr, `PITC_CH_CTL, N_CHAN)) begin
            rd_data = 32'(ch[CW'(ri)]);
        end else if (in_area(araddr, `PITC_CH_SRC, N_CHAN)) begin
            rd_data = 32'(ch_src[CW'(ri)]);
        end else if (in_area(araddr, `PITC_CH_DST, N_CHAN)) begin
            rd_data = 32'(ch_dst[CW'(ri)]);
        end else begin
            unique case (araddr)
                `PITC_PSW: rd_data = 32'(processor_status_word);
                `PITC_TFR: rd_data = 32'(trap_flag_register);
                `PITC_SP: rd_data = 32'(sp);
                `PITC_STK_UP: rd_data = 32'(stk_upper);
                `PITC_STK_LO: rd_data = 32'(stk_lower);
                `PITC_STATUS: rd_data = {16'h0000, trap_cur,
                                         6'h00, irq_valid, svc};
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `PITC_RESP_OK;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_map_ok(araddr) ? `PITC_RESP_OK : `PITC_RESP_ERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stall_with_move: assert property (xfer_valid |-> cpu_stall)
        else $error("transfer without its stolen cycle");
    a_irq_above_level: assert property (
        irq_valid |-> irq_level > $past(processor_status_word[`PITC_PSW_LVL]))
        else $error("interrupt not above cpu level");
    a_trap_blocks_all: assert property (
        svc == pitc_pkg::SV_TRAP |-> !irq_valid && !xfer_valid)
        else $error("service raised during trap");
    a_irq_vector_map: assert property (
        irq_valid |-> irq_vector == vec_of(`PITC_IRQ_VEC_BASE, 8'(irq_idx)))
        else $error("wrong source vector");
    a_push_on_ack: assert property (
        irq_valid && cpu_ack |=> stk_push && stk_data == $past(processor_status_word))
        else $error("state not pushed on acknowledge");
    a_stack_over: assert property (
        stk_push && $past(stk_upper) == stk_upper && stk_addr < stk_upper
        |-> trap_flag_register[`PITC_TRAP_STACK_UPPER_LIMIT])
        else $error("overflow not flagged");
    a_count_down: assert property (
        do_xfer && !chs.cont |=> ch[$past(cur_ch)].count ==
        $past(chs.count) - 8'h01)
        else $error("counter not decremented");
    a_fast_window: assert property (fast_tick |=> !fast_tick [*8])
        else $error("fast sample window too short");
    a_trap_preempt: assert property (
        trap_valid |-> $past(svc) == pitc_pkg::SV_TASK ||
        $past(trap_idx) < $past(trap_cur))
        else $error("trap raised over higher trap");

    c_transfer: cover property (xfer_valid);
    c_irq_taken: cover property (irq_valid && cpu_ack);
    c_trap_taken: cover property (trap_valid && trap_ack);
endmodule // pitc_top

// ==== test/pitc_cpu_model.sv ====
// cpu side model: takes every offered interrupt and trap
// assumes same-clock valid outputs from the controller
`timescale 1ns/10ps
module pitc_cpu_model (
    input wire logic en,
    input wire logic irq_valid,
    input wire logic trap_valid,
    output logic cpu_ack,
    output logic trap_ack
);
    assign cpu_ack = en & irq_valid;
    assign trap_ack = en & trap_valid;
endmodule // pitc_cpu_model

// ==== test/tb_pitc_top.sv ====
// bench for the interrupt controller: axi4-lite tasks and pin pulses
// assumes the cpu model acks at once and pins pass a 2-3 cycle sync
`timescale 1ns/10ps
module tb_pitc_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, swi_valid = 0, cpu_ack, trap_ack;
    logic awready, wready, bvalid, arready, rvalid, irq_valid;
    logic trap_valid, xfer_valid, cpu_stall, stk_push;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, swi_num = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [21:0] pins = 22'h0;
    logic [3:0] fpin = 4'h0;
    logic mdu_busy = 1'b0, mdu_abort;
    logic [15:0] irq_vector, trap_vector, swi_vector, ivec, tvec;
    pitc_pkg::pitc_move_t xfer_move, mv;
    int cnt [5] = '{0, 0, 0, 0, 0};
    int errors = 0, cmp_count = 0;
    always #2 aclk = ~aclk;
    pitc_top i_pitc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .src_pin(pins[15:0]), .fast_pin(fpin), .trap_pin(pins[21:16]),
        .cpu_ack, .trap_ack, .swi_valid, .swi_num, .reti(1'b0),
        .reti_psw(16'h0000), .mdu_busy, .irq_valid, .irq_vector,
        .irq_level(), .trap_valid, .trap_vector, .swi_vector,
        .mdu_abort, .xfer_valid, .xfer_move, .cpu_stall, .stk_push,
        .stk_addr(), .stk_data());
    pitc_cpu_model i_pitc_cpu_model (.en(aresetn), .irq_valid,
        .trap_valid, .cpu_ack, .trap_ack);
    always @(negedge aclk) begin
        if (mdu_abort) cnt[4]++;
        if (irq_valid && cpu_ack) begin
            cnt[0]++;
            ivec = irq_vector;
        end
        if (xfer_valid) begin
            cnt[1]++;
            mv = xfer_move;
            chk(cpu_stall, 1'b1);
        end
        if (trap_valid && trap_ack) begin
            cnt[2]++;
            tvec = trap_vector;
        end
        if (stk_push) cnt[3]++;
    end
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [33:0] s, input logic [33:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task tmo(input int i);
        if (i >= 200) begin
            errors++;
            end_sim;
        end
    endtask
    task wt(input int k, input int n);
        int i;
        for (i = 0; i < 200 && cnt[k] < n; i++) @(negedge aclk);
        tmo(i);
        chk(cnt[k], n);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(i);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(i);
        chk({rresp, rdata}, {r, e});
    endtask
    task pulse(input int n);
        @(posedge aclk);
        pins[n] <= 1'b1;
        repeat (4) @(posedge aclk);
        pins[n] <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h48, 32'hFC00, 2'h0);
        rc(8'h4C, 32'hF400, 2'h0);
        rc(8'h50, 32'hFC00, 2'h0);
        rc(8'h60, 32'h0, 2'h2);
        $display("test reset done");
        wr(8'h00, 32'h16);
        pulse(0);
        wt(0, 1);
        chk(ivec, 16'h0040);
        wt(3, 1);
        rc(8'h40, 32'h5000, 2'h0);
        rc(8'h00, 32'h16, 2'h0);
        wr(8'h04, 32'h0E);
        pulse(1);
        repeat (20) @(negedge aclk);
        chk(cnt[0], 1);
        $display("test irq done");
        wr(8'h80, 32'h302);
        wr(8'hA0, 32'h1000);
        wr(8'hC0, 32'h2000);
        wr(8'h08, 32'h81E);
        pulse(2);
        wt(1, 1);
        chk(mv, {1'b1, 16'h1000, 16'h2000});
        chk(cnt[3], 1);
        rc(8'hA0, 32'h1002, 2'h0);
        rc(8'h80, 32'h301, 2'h0);
        pulse(2);
        wt(1, 2);
        wt(0, 2);
        chk(ivec, 16'h0048);
        $display("test transfer done");
        wr(8'h0C, 32'h3E);
        mdu_busy <= 1'b1;
        fpin[3] <= 1'b1;
        @(posedge aclk);
        fpin[3] <= 1'b0;
        wt(0, 3);
        chk(ivec, 16'h004C);
        repeat (3) @(posedge aclk);
        mdu_busy <= 1'b0;
        chk(cnt[4], 1);
        $display("test fast done");
        @(posedge aclk);
        swi_num <= 8'h03;
        swi_valid <= 1'b1;
        @(posedge aclk);
        swi_valid <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
        chk(swi_vector, 16'h000C);
        pulse(16);
        wt(2, 1);
        chk(tvec, 16'h0008);
        rc(8'h44, 32'h4, 2'h0);
        wr(8'h44, 32'h4);
        rc(8'h44, 32'h0, 2'h0);
        wr(8'h0C, 32'h3E);
        pulse(3);
        repeat (20) @(negedge aclk);
        chk(cnt[0], 3);
        $display("test trap done");
        end_sim;
    end
endmodule // tb_pitc_top
